/* File: design/pens_defines.vh */
/*
  Constants of the phase event and no-load status bank: register offsets,
  field positions, reset values and the energy-to-pulse threshold.
  Assumes it is included by bare name from each design file that needs it.
*/
// What this block does
// [R1] Overcurrent event latches causing phases into event-source bits 5:3.
// [R2] Overvoltage event latches causing phases into event-source bits 11:9.
// [R3] Voltage-dip event latches causing phases into event-source bits 14:12.
// [R4] Event-source reserved bits 2:0, 8:6, 15 read zero; reset is zero.
// [R5] Total no-load phase bits 2:0 set together with main status bit 0.
// [R6] No-load bits follow their condition level; all reset to zero.
// [R7] Without reactive measurement, total no-load uses active power only.
// [R8] Fundamental no-load phase bits 5:3 set together with status bit 1.
// [R9] Without fundamental measurement, fundamental no-load bits stay zero.
// [R10] Apparent no-load phase bits 8:6 set together with status bit 2.
// [R11] No-load register bits 15:9 always read zero.
// [R12] Select bits 2:0 pick phases for pulse output one; reset ones.
// [R13] Select bits 5:3 pick phases for pulse output two; reset ones.
// [R14] Select bits 6,7 pick phases A,B for pulse output three; reset ones.
// [R15] All three select bits set drives the output from the three-phase sum.
// [R16] Select bit 8 picks phase C for pulse output three; reset one.
// [R17] Indicator registers are read-only, refreshed with each summary flag.
`ifndef PENS_DEFINES_VH
`define PENS_DEFINES_VH

// Register offsets on the plain register port.
`define PENS_ADDR_EVENT_SRC  16'he600
`define PENS_ADDR_PULSE_SEL  16'he606
`define PENS_ADDR_NOLOAD     16'he608
`define PENS_ADDR_MAIN_STAT  16'he610
`define PENS_ADDR_MAIN_MASK  16'he611

// Field positions in the event-source register.
`define PENS_OC_LSB   4'd3
`define PENS_OV_LSB   4'd9
`define PENS_DIP_LSB  4'd12

// Field positions in the no-load register.
`define PENS_TOT_LSB  4'd0
`define PENS_FUND_LSB 4'd3
`define PENS_APP_LSB  4'd6

// Field positions in the pulse phase-select register.
`define PENS_SEL1_LSB 4'd0
`define PENS_SEL2_LSB 4'd3
`define PENS_SEL3_LSB 4'd6

// Bit positions in the main event status and mask registers.
`define PENS_ST_TOT   5'd0
`define PENS_ST_FUND  5'd1
`define PENS_ST_APP   5'd2
`define PENS_ST_DIP   5'd16
`define PENS_ST_OC    5'd17
`define PENS_ST_OV    5'd18
`define PENS_ST_USED  32'h00070007

// Reset values.
`define PENS_EVENT_RESET   3'h0
`define PENS_NOLOAD_RESET  3'h0
`define PENS_SEL_RESET     9'h1ff
`define PENS_STAT_RESET    32'h00000000
`define PENS_MASK_RESET    32'h00000000

// Energy units per output pulse; above the largest three-phase step.
`define PENS_PULSE_THRESH  24'h040000

`endif

/* File: design/pens_phase_sum.v */
/*
  Phase selector and adder feeding one pulse output accumulation.
  Assumes the three phase energy steps arrive together on one clock.
*/
`timescale 1ns/1ps
module pens_phase_sum
(
  // Phase selection, bit 0 phase A up to bit 2 phase C.
  input  wire [2:0]  phaseSel,
  // Energy steps of the three phases.
  input  wire [15:0] energyA,
  input  wire [15:0] energyB,
  input  wire [15:0] energyC,
  // Sum of the selected phases.
  output wire [17:0] selSum
);

  wire [17:0] termA;
  wire [17:0] termB;
  wire [17:0] termC;

  // A cleared select bit removes its phase; all three set gives the
  // full three-phase sum with no special case. [R15]
  assign termA  = phaseSel[0] ? {2'h0, energyA} : 18'h00000;
  assign termB  = phaseSel[1] ? {2'h0, energyB} : 18'h00000;
  assign termC  = phaseSel[2] ? {2'h0, energyC} : 18'h00000;
  assign selSum = termA + termB + termC;

endmodule

/* File: design/pens_status_regs.v */
/*
  Phase event source, per-phase no-load state and pulse phase-select
  registers, with the main event status, its mask and the interrupt.
  Also accumulates selected phase energy into three pulse outputs.
  Assumes detector, no-load and energy inputs come from logic on clk,
  so none of them is synchronised here.
*/
`timescale 1ns/1ps
`include "pens_defines.vh"
module pens_status_regs
#(
  parameter integer REACTIVE_PRESENT    = 1,
  parameter integer FUNDAMENTAL_PRESENT = 1
)
(
  // Clock, reset and clock enable.
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  // Register port.
  input  wire [15:0] addr,
  input  wire [31:0] wrData,
  input  wire        wrEn,
  input  wire        rdEn,
  output reg  [31:0] rdData,
  // Per-phase event detectors, one-cycle pulses.
  input  wire [2:0]  overcurrentHit,
  input  wire [2:0]  highVoltageHit,
  input  wire [2:0]  voltageDipHit,
  // Per-phase no-load condition levels.
  input  wire [2:0]  totalActiveIdle,
  input  wire [2:0]  totalReactiveIdle,
  input  wire [2:0]  fundActiveIdle,
  input  wire [2:0]  fundReactiveIdle,
  input  wire [2:0]  apparentIdle,
  // Per-phase energy steps.
  input  wire        energyValid,
  input  wire [15:0] energyA,
  input  wire [15:0] energyB,
  input  wire [15:0] energyC,
  // Interrupt and pulse outputs.
  output reg         irq,
  output reg         pulseOutputOne,
  output reg         pulseOutputTwo,
  output reg         pulseOutputThree
);

  // Register state.
  reg  [2:0]  overcurrentPhaseInd;
  reg  [2:0]  highVoltagePhaseInd;
  reg  [2:0]  voltageDipPhaseInd;
  reg  [2:0]  totalIdlePhaseInd;
  reg  [2:0]  fundamentalIdlePhaseInd;
  reg  [2:0]  apparentIdlePhaseInd;
  reg  [8:0]  pulsePhaseSelect;
  reg  [31:0] mainEventStatus;
  reg  [31:0] mainEventMask;
  reg  [23:0] accOne;
  reg  [23:0] accTwo;
  reg  [23:0] accThree;

  // Next values and helpers.
  reg  [31:0] next_mainEventStatus;
  reg  [31:0] next_mainEventMask;
  reg  [31:0] statusSet;
  reg  [31:0] statusClr;
  reg  [31:0] readValue;
  wire [2:0]  totalIdleNow;
  wire [2:0]  fundIdleNow;
  wire        overcurrentEvent;
  wire        highVoltageEvent;
  wire        voltageDipEvent;
  wire        totalIdleEnter;
  wire        fundIdleEnter;
  wire        apparentIdleEnter;
  wire [15:0] eventSourceWord;
  wire [15:0] noloadStateWord;
  wire [17:0] sumOne;
  wire [17:0] sumTwo;
  wire [17:0] sumThree;
  wire [24:0] stepOne;
  wire [24:0] stepTwo;
  wire [24:0] stepThree;
  wire        wrStat;
  wire        wrMask;
  wire        wrSel;

  // A phase entering a no-load condition: high now, low before.
  function idleRise;
    input [2:0] cur;
    input [2:0] prev;
    begin
      idleRise = |(cur & ~prev);
    end
  endfunction

  // One accumulation step: adds the selected sum and, on reaching the
  // threshold, removes one quantum and reports a pulse in the top bit.
  // The threshold exceeds the largest sum, so the residue stays bounded.
  function [24:0] accStep;
    input [23:0] acc;
    input [17:0] add;
    reg   [23:0] grown;
    begin
      grown = acc + {6'h00, add};
      if (grown >= `PENS_PULSE_THRESH)
      begin
        accStep = {1'b1, grown - `PENS_PULSE_THRESH};
      end
      else
      begin
        accStep = {1'b0, grown};
      end
    end
  endfunction

  // Address decode for writes; read-only registers have no write term.
  // Writes to the two read-only images fall through the decode and are lost.
  assign wrStat = wrEn && (addr == `PENS_ADDR_MAIN_STAT);
  assign wrMask = wrEn && (addr == `PENS_ADDR_MAIN_MASK);
  assign wrSel  = wrEn && (addr == `PENS_ADDR_PULSE_SEL);

  // Summary events raised by any phase.
  // A hit on several phases at once raises one flag, not one per phase.
  assign overcurrentEvent = |overcurrentHit;
  assign highVoltageEvent = |highVoltageHit;
  assign voltageDipEvent  = |voltageDipHit;

  // The reduced variant has no reactive path, so total no-load looks at
  // active power alone. [R7]
  assign totalIdleNow = (REACTIVE_PRESENT != 0) ?
                        (totalActiveIdle & totalReactiveIdle) :
                        totalActiveIdle;

  // Without fundamental measurement these bits are tied low. [R9]
  assign fundIdleNow = (FUNDAMENTAL_PRESENT != 0) ?
                       (fundActiveIdle & fundReactiveIdle) :
                       3'h0;

  // Entries into no-load raise the summary flags.
  assign totalIdleEnter    = idleRise(totalIdleNow, totalIdlePhaseInd);
  assign fundIdleEnter     = idleRise(fundIdleNow, fundamentalIdlePhaseInd);
  assign apparentIdleEnter = idleRise(apparentIdle, apparentIdlePhaseInd);

  // Read images; unused positions are constant zero. [R4] [R11]
  assign eventSourceWord = {1'b0, voltageDipPhaseInd, highVoltagePhaseInd,
                            3'h0, overcurrentPhaseInd, 3'h0};
  assign noloadStateWord = {7'h00, apparentIdlePhaseInd,
                            fundamentalIdlePhaseInd, totalIdlePhaseInd};

  // Sticky status: hardware sets, software clears by writing ones, and a
  // set in the same cycle as its clear wins so no event is lost.
  // Only the six used positions can ever hold a one.
  always @*
  begin
    statusSet = 32'h00000000;
    statusSet[`PENS_ST_OC]   = overcurrentEvent;
    statusSet[`PENS_ST_OV]   = highVoltageEvent;
    statusSet[`PENS_ST_DIP]  = voltageDipEvent;
    statusSet[`PENS_ST_TOT]  = totalIdleEnter;    // [R5]
    statusSet[`PENS_ST_FUND] = fundIdleEnter;     // [R8]
    statusSet[`PENS_ST_APP]  = apparentIdleEnter; // [R10]
    statusClr = wrStat ? (wrData & `PENS_ST_USED) : 32'h00000000;
    next_mainEventStatus = (mainEventStatus & ~statusClr) | statusSet;
    next_mainEventMask = wrMask ? (wrData & `PENS_ST_USED) : mainEventMask;
  end

  // Event-source indicators are overwritten with the causing phases each
  // time the summary event fires, and hold otherwise; software cannot
  // write them, so a stale value only shows the last event. [R17]
  // One event may mark several phases in the same field.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      overcurrentPhaseInd <= `PENS_EVENT_RESET;  // [R4]
      highVoltagePhaseInd <= `PENS_EVENT_RESET;
      voltageDipPhaseInd  <= `PENS_EVENT_RESET;
    end
    else if (ce)
    begin
      if (overcurrentEvent)
      begin
        overcurrentPhaseInd <= overcurrentHit;   // [R1]
      end
      if (highVoltageEvent)
      begin
        highVoltagePhaseInd <= highVoltageHit;   // [R2]
      end
      if (voltageDipEvent)
      begin
        voltageDipPhaseInd <= voltageDipHit;     // [R3]
      end
    end
  end

  // No-load bits are live levels, one cycle behind the condition, and
  // land in the same edge as the matching summary flag. [R6]
  // Leaving no-load clears a bit with no action from software.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      totalIdlePhaseInd       <= `PENS_NOLOAD_RESET;
      fundamentalIdlePhaseInd <= `PENS_NOLOAD_RESET;
      apparentIdlePhaseInd    <= `PENS_NOLOAD_RESET;
    end
    else if (ce)
    begin
      totalIdlePhaseInd       <= totalIdleNow;  // [R5]
      fundamentalIdlePhaseInd <= fundIdleNow;   // [R8] [R9]
      apparentIdlePhaseInd    <= apparentIdle;  // [R10]
    end
  end

  // Main status, mask and interrupt; the interrupt is taken from the
  // next values so it rises in the same edge as the status bit.
  // Writing the mask alone can therefore raise or drop the interrupt.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mainEventStatus <= `PENS_STAT_RESET;
      mainEventMask   <= `PENS_MASK_RESET;
      irq             <= 1'b0;
    end
    else if (ce)
    begin
      mainEventStatus <= next_mainEventStatus;
      mainEventMask   <= next_mainEventMask;
      irq             <= |(next_mainEventStatus & next_mainEventMask);
    end
  end

  // Phase select register; every phase is included out of reset.
  // Only the nine select bits are stored; upper write data is dropped.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pulsePhaseSelect <= `PENS_SEL_RESET;  // [R12] [R13] [R14] [R16]
    end
    else if (ce && wrSel)
    begin
      pulsePhaseSelect <= wrData[8:0];
    end
  end

  // Selected-phase sums, one per pulse output.
  // Each output has its own adder so the three selections stay independent.
  pens_phase_sum sumFirst
  (
    .phaseSel (pulsePhaseSelect[`PENS_SEL1_LSB +: 3]),  // [R12]
    .energyA  (energyA),
    .energyB  (energyB),
    .energyC  (energyC),
    .selSum   (sumOne)
  );

  pens_phase_sum sumSecond
  (
    .phaseSel (pulsePhaseSelect[`PENS_SEL2_LSB +: 3]),  // [R13]
    .energyA  (energyA),
    .energyB  (energyB),
    .energyC  (energyC),
    .selSum   (sumTwo)
  );

  pens_phase_sum sumThird
  (
    .phaseSel (pulsePhaseSelect[`PENS_SEL3_LSB +: 3]),  // [R14] [R16]
    .energyA  (energyA),
    .energyB  (energyB),
    .energyC  (energyC),
    .selSum   (sumThree)
  );

  assign stepOne   = accStep(accOne, sumOne);      // [R15]
  assign stepTwo   = accStep(accTwo, sumTwo);
  assign stepThree = accStep(accThree, sumThree);

  // Energy accumulators; a pulse lasts one cycle per threshold crossing.
  // A change of selection applies from the next energy step onward.
  // The residue is kept across such a change, so no energy is dropped.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      accOne           <= 24'h000000;
      accTwo           <= 24'h000000;
      accThree         <= 24'h000000;
      pulseOutputOne   <= 1'b0;
      pulseOutputTwo   <= 1'b0;
      pulseOutputThree <= 1'b0;
    end
    else if (ce)
    begin
      if (energyValid)
      begin
        accOne           <= stepOne[23:0];
        accTwo           <= stepTwo[23:0];
        accThree         <= stepThree[23:0];
        pulseOutputOne   <= stepOne[24];
        pulseOutputTwo   <= stepTwo[24];
        pulseOutputThree <= stepThree[24];
      end
      else
      begin
        pulseOutputOne   <= 1'b0;
        pulseOutputTwo   <= 1'b0;
        pulseOutputThree <= 1'b0;
      end
    end
  end

  // Read decode; unmapped addresses read zero.
  // Decoding uses the full address, so no register has an alias.
  always @*
  begin
    case (addr)
      `PENS_ADDR_EVENT_SRC: readValue = {16'h0000, eventSourceWord};
      `PENS_ADDR_NOLOAD:    readValue = {16'h0000, noloadStateWord};
      `PENS_ADDR_PULSE_SEL: readValue = {23'h000000, pulsePhaseSelect};
      `PENS_ADDR_MAIN_STAT: readValue = mainEventStatus;
      `PENS_ADDR_MAIN_MASK: readValue = mainEventMask;
      default:              readValue = 32'h00000000;
    endcase
  end

  // Read data stand for exactly the cycle after the strobe and are zero
  // otherwise, so a stale value is never mistaken for an answer.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdData <= 32'h00000000;
    end
    else if (ce)
    begin
      rdData <= rdEn ? readValue : 32'h00000000;
    end
  end

endmodule

/* File: dv/pens_status_regs_checker.sv */
/*
  Checker of the phase event and no-load status bank.
  Assumes one clock, rst asynchronous active high, and ce high around
  every register access.
*/
`timescale 1ns/1ps
module pens_status_regs_checker
#(
  parameter integer REACTIVE_PRESENT    = 1,
  parameter integer FUNDAMENTAL_PRESENT = 1
)
(
  // Clock, reset and register port.
  input wire        clk,
  input wire        rst,
  input wire        ce,
  input wire [15:0] addr,
  input wire [31:0] wrData,
  input wire        wrEn,
  input wire        rdEn,
  input wire [31:0] rdData,
  // Detectors and no-load levels.
  input wire [2:0]  overcurrentHit,
  input wire [2:0]  highVoltageHit,
  input wire [2:0]  voltageDipHit,
  input wire [2:0]  totalActiveIdle,
  input wire [2:0]  totalReactiveIdle,
  input wire [2:0]  fundActiveIdle,
  input wire [2:0]  fundReactiveIdle,
  input wire [2:0]  apparentIdle,
  // Energy strobe and outputs.
  input wire        energyValid,
  input wire        irq,
  input wire        pulseOutputThree
);
  reg  [8:0] evt;
  wire [8:0] noloadNow;
  wire [2:0] evHit;
  wire [8:0] wrSel;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Expected levels and causes, kept beside the bank for comparison.
  assign noloadNow = {apparentIdle,
                      (FUNDAMENTAL_PRESENT != 0) ?
                      (fundActiveIdle & fundReactiveIdle) : 3'h0,
                      (REACTIVE_PRESENT != 0) ?
                      (totalActiveIdle & totalReactiveIdle) :
                      totalActiveIdle};
  assign evHit = {|highVoltageHit, |overcurrentHit, |voltageDipHit};
  assign wrSel = wrData[8:0];

  // Last phase vector of each event kind; a new event overwrites it.
  always @(posedge clk or posedge rst)
    if (rst)
      evt <= 9'h000;
    else if (ce)
    begin
      if (|overcurrentHit) evt[2:0] <= overcurrentHit;
      if (|highVoltageHit) evt[5:3] <= highVoltageHit;
      if (|voltageDipHit) evt[8:6] <= voltageDipHit;
    end

  a_event_rsv_zero: assert property
    (rdEn && addr == 16'he600 |=> (rdData & 32'hffff81c7) == 32'h0)
    else $error("reserved event source bits not zero");
  a_noload_rsv_zero: assert property
    (rdEn && addr == 16'he608 |=> rdData[31:9] == 23'h0)
    else $error("reserved no-load bits not zero");
  a_event_fields: assert property
    (rdEn && addr == 16'he600 && evHit == 3'h0 |=>
     rdData[14:3] == {evt[8:6], evt[5:3], 3'h0, evt[2:0]})
    else $error("event phase field differs from last event");
  a_event_status: assert property
    (ce && evHit != 3'h0 ##1 !wrEn ##1 (rdEn && addr == 16'he610) |=>
     (rdData[18:16] & $past(evHit, 3)) == $past(evHit, 3))
    else $error("event status bit missing after event");
  a_noload_follow: assert property
    (rdEn && addr == 16'he608 |=> rdData[8:0] == $past(noloadNow, 2))
    else $error("no-load bits do not follow levels");
  a_select_rdback: assert property
    (wrEn && addr == 16'he606 ##1 !wrEn ##1 rdEn && addr == 16'he606
     |=> rdData[8:0] == $past(wrSel, 3))
    else $error("phase select read back differs");
  a_pulse_quiet: assert property
    (!energyValid |=> !pulseOutputThree)
    else $error("pulse without energy step");
  a_irq_masked_off: assert property
    (wrEn && addr == 16'he611 && wrData == 32'h0 ##1
     !(wrEn && addr == 16'he611) |=> !irq)
    else $error("interrupt high with all masked");

  c_irq_rise: cover property ($rose(irq));
  c_pulse_three: cover property (pulseOutputThree);
  c_noload_read: cover property (rdEn && addr == 16'he608);
endmodule

bind pens_status_regs pens_status_regs_checker
  #(.REACTIVE_PRESENT(REACTIVE_PRESENT),
    .FUNDAMENTAL_PRESENT(FUNDAMENTAL_PRESENT))
  chk_u (.clk(clk), .rst(rst),
  .ce(ce), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
  .rdData(rdData), .overcurrentHit(overcurrentHit),
  .highVoltageHit(highVoltageHit), .voltageDipHit(voltageDipHit),
  .totalActiveIdle(totalActiveIdle), .totalReactiveIdle(totalReactiveIdle),
  .fundActiveIdle(fundActiveIdle), .fundReactiveIdle(fundReactiveIdle),
  .apparentIdle(apparentIdle), .energyValid(energyValid), .irq(irq),
  .pulseOutputThree(pulseOutputThree));

/* File: dv/pens_status_regs_tb_top.sv */
/*
  Self-checking bench of the status bank through its register port.
  Assumes pens_defines.vh is on the include path.
*/
`timescale 1ns/1ps
`include "pens_defines.vh"
module pens_status_regs_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic [15:0] addr = 16'h0;
  logic [31:0] wrData = 32'h0;
  logic        wrEn = 1'b0;
  logic        rdEn = 1'b0;
  logic [2:0]  overcurrentHit = 3'h0;
  logic [2:0]  highVoltageHit = 3'h0;
  logic [2:0]  voltageDipHit = 3'h0;
  logic [2:0]  totalActiveIdle = 3'h0;
  logic [2:0]  totalReactiveIdle = 3'h0;
  logic [2:0]  fundActiveIdle = 3'h0;
  logic [2:0]  fundReactiveIdle = 3'h0;
  logic [2:0]  apparentIdle = 3'h0;
  logic        energyValid = 1'b0;
  logic [15:0] energyA = 16'h2000;
  logic [15:0] energyB = 16'h4000;
  logic [15:0] energyC = 16'h8000;
  wire  [31:0] rdData;
  wire  [31:0] liteRdData;
  wire         irq;
  wire         pulseOutputOne;
  wire         pulseOutputTwo;
  wire         pulseOutputThree;
  integer      fails = 0;
  integer      n_compared = 0;
  integer      cycles = 0;
  integer      cnt1 = 0;
  integer      cnt2 = 0;
  integer      cnt3 = 0;
  integer      k;
  integer      lsb [3] = '{3, 9, 12};
  integer      sbit [3] = '{17, 18, 16};
  logic [31:0] exp600 = 32'h0;
  logic [31:0] expSt = 32'h0;

  pens_status_regs dut_u (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
    .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
    .overcurrentHit(overcurrentHit), .highVoltageHit(highVoltageHit),
    .voltageDipHit(voltageDipHit), .totalActiveIdle(totalActiveIdle),
    .totalReactiveIdle(totalReactiveIdle), .fundActiveIdle(fundActiveIdle),
    .fundReactiveIdle(fundReactiveIdle), .apparentIdle(apparentIdle),
    .energyValid(energyValid), .energyA(energyA), .energyB(energyB),
    .energyC(energyC), .irq(irq), .pulseOutputOne(pulseOutputOne),
    .pulseOutputTwo(pulseOutputTwo), .pulseOutputThree(pulseOutputThree));

  // Reduced variant: no reactive and no fundamental measurement.
  pens_status_regs #(.REACTIVE_PRESENT(0), .FUNDAMENTAL_PRESENT(0)) lite_u (
    .clk(clk), .rst(rst), .ce(ce), .addr(addr), .wrData(wrData),
    .wrEn(wrEn), .rdEn(rdEn), .rdData(liteRdData),
    .overcurrentHit(overcurrentHit), .highVoltageHit(highVoltageHit),
    .voltageDipHit(voltageDipHit), .totalActiveIdle(totalActiveIdle),
    .totalReactiveIdle(totalReactiveIdle), .fundActiveIdle(fundActiveIdle),
    .fundReactiveIdle(fundReactiveIdle), .apparentIdle(apparentIdle),
    .energyValid(energyValid), .energyA(energyA), .energyB(energyB),
    .energyC(energyC), .irq(), .pulseOutputOne(), .pulseOutputTwo(),
    .pulseOutputThree());

  // 200 MHz clock.
  always #2.5 clk = ~clk;

  // Pulse counters; a hang is cut off well beyond the expected run.
  always @(posedge clk)
  begin
    cnt1 <= cnt1 + pulseOutputOne;
    cnt2 <= cnt2 + pulseOutputTwo;
    cnt3 <= cnt3 + pulseOutputThree;
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fails = fails + 1;
      test_done;
    end
  end

  task test_done;
  begin
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask

  task chk(input string nm, input [31:0] e, input [31:0] g);
  begin
    n_compared = n_compared + 1;
    if (g !== e)
    begin
      fails = fails + 1;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  end
  endtask

  // One-cycle write strobe, then released before the next access.
  task wr(input [15:0] a, input [31:0] d);
  begin
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
  end
  endtask

  // Read data stand only in the cycle after the strobe.
  task rd(input [15:0] a, input [31:0] e);
  begin
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 0;
    #1 chk("rdData", e, rdData);
  end
  endtask

  task hit(input integer kk, input [2:0] v);
  begin
    @(posedge clk);
    case (kk)
      0: overcurrentHit <= v;
      1: highVoltageHit <= v;
      default: voltageDipHit <= v;
    endcase
    @(posedge clk);
    overcurrentHit <= 3'h0;
    highVoltageHit <= 3'h0;
    voltageDipHit <= 3'h0;
  end
  endtask

  // Two edges allow for the registered interrupt to settle.
  task irqChk(input [31:0] e);
  begin
    repeat (2) @(posedge clk);
    #1 chk("irq", e, {31'h0, irq});
  end
  endtask

  function integer nPulse(input [2:0] f);
    nPulse = (64 * ((f[0] ? energyA : 0) + (f[1] ? energyB : 0)
             + (f[2] ? energyC : 0))) / `PENS_PULSE_THRESH;
  endfunction

  // 64 energy steps; every sum is a whole number of thresholds.
  task run(input [8:0] s);
    integer b1, b2, b3;
  begin
    wr(16'he606, {23'h0, s});
    rd(16'he606, {23'h0, s});
    b1 = cnt1;
    b2 = cnt2;
    b3 = cnt3;
    @(posedge clk);
    energyValid <= 1'b1;
    repeat (64) @(posedge clk);
    energyValid <= 1'b0;
    repeat (3) @(posedge clk);
    chk("pulseOutputOne", nPulse(s[2:0]), cnt1 - b1);
    chk("pulseOutputTwo", nPulse(s[5:3]), cnt2 - b2);
    chk("pulseOutputThree", nPulse(s[8:6]), cnt3 - b3);
  end
  endtask

  // Main sequence.
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(16'he600, 32'h0);
    rd(16'he608, 32'h0);
    rd(16'he606, 32'h1ff);
    for (k = 0; k < 3; k = k + 1)
    begin
      hit(k, 3'b101);
      expSt = expSt | (32'h1 << sbit[k]);
      rd(16'he610, expSt);
      hit(k, 3'b010);
      exp600 = (exp600 & ~(32'h7 << lsb[k])) | (32'h2 << lsb[k]);
      rd(16'he600, exp600);
    end
    wr(16'he610, 32'h70000);
    rd(16'he610, 32'h0);
    // A hit while the clock enable is low must leave no trace.
    @(posedge clk);
    ce <= 1'b0;
    hit(0, 3'b100);
    ce <= 1'b1;
    rd(16'he610, 32'h0);
    wr(16'he600, 32'hffffffff);
    rd(16'he600, exp600);
    wr(16'he608, 32'hffffffff);
    rd(16'he608, 32'h0);
    rd(16'he6ff, 32'h0);
    wr(16'he611, 32'hffffffff);
    rd(16'he611, `PENS_ST_USED);
    wr(16'he611, 32'h20000);
    irqChk(0);
    hit(0, 3'b001);
    irqChk(1);
    wr(16'he611, 32'h0);
    irqChk(0);
    wr(16'he611, 32'h20000);
    irqChk(1);
    wr(16'he610, 32'h20000);
    irqChk(0);
    @(posedge clk);
    totalActiveIdle <= 3'b011;
    totalReactiveIdle <= 3'b101;
    fundActiveIdle <= 3'b110;
    fundReactiveIdle <= 3'b110;
    apparentIdle <= 3'b100;
    repeat (3) @(posedge clk);
    rd(16'he608, 32'h131);
    chk("liteRdData", 32'h103, liteRdData);
    rd(16'he610, 32'h7);
    @(posedge clk);
    totalActiveIdle <= 3'b000;
    fundActiveIdle <= 3'b000;
    apparentIdle <= 3'b000;
    repeat (3) @(posedge clk);
    rd(16'he608, 32'h0);
    chk("liteRdData", 32'h0, liteRdData);
    run(9'h00f);
    run(9'h110);
    run(9'h0e1);
    test_done;
  end
endmodule
